// File: pcg_pkg.sv
package pcg_pkg;
   // Register offsets from the system control base
   localparam logic [11:0] PCG_OFF_GATE_ONE = 12'h104;
   localparam logic [11:0] PCG_OFF_RUN_TWO = 12'h108;
   localparam logic [11:0] PCG_OFF_SLEEP_ONE = 12'h114;
   localparam logic [11:0] PCG_OFF_SLEEP_TWO = 12'h118;
   localparam logic [11:0] PCG_OFF_DEEP_ONE = 12'h124;
   localparam logic [11:0] PCG_OFF_DEEP_TWO = 12'h128;
   localparam logic [11:0] PCG_OFF_CLK_CFG = 12'h060;
   localparam logic [11:0] PCG_OFF_MODE = 12'h200;
   localparam logic [11:0] PCG_OFF_FAULT_ADDR = 12'h204;
   localparam logic [11:0] PCG_OFF_INT_STAT = 12'h208;
   localparam logic [11:0] PCG_OFF_INT_MASK = 12'h20C;
   localparam logic [31:0] PCG_SYSCTL_BASE = 32'h400FE000;
   // Field positions
   localparam int PCG_BIT_GP_TIMER_ZERO = 16;
   localparam int PCG_BIT_SYNC_SERIAL_ZERO = 4;
   localparam int PCG_BIT_ASYNC_SERIAL_ZERO = 0;
   localparam int PCG_BIT_AUTO_GATING = 27;
   localparam int PCG_PORT_COUNT = 5;
   localparam int PCG_UNIT_COUNT = 8;
   localparam logic [31:0] PCG_MASK_ONE = 32'h00010011;
   localparam logic [31:0] PCG_MASK_TWO = 32'h0000001F;
   localparam logic [31:0] PCG_MASK_CFG = 32'h08000000;
   localparam logic [31:0] PCG_RESET_VALUE = 32'h00000000;
   // Peripheral windows, 4 KB each, index from address bits 19:12
   localparam logic [7:0] PCG_PAGE_GP_TIMER_ZERO = 8'h30;
   localparam logic [7:0] PCG_PAGE_SYNC_SERIAL_ZERO = 8'h08;
   localparam logic [7:0] PCG_PAGE_ASYNC_SERIAL_ZERO = 8'h0C;
   localparam logic [7:0] PCG_PAGE_PORT_A = 8'h04;
   localparam logic [7:0] PCG_PAGE_PORT_B = 8'h05;
   localparam logic [7:0] PCG_PAGE_PORT_C = 8'h06;
   localparam logic [7:0] PCG_PAGE_PORT_D = 8'h07;
   localparam logic [7:0] PCG_PAGE_PORT_E = 8'h24;
   localparam logic [11:0] PCG_PERIPH_TOP = 12'h400;
   // Power modes
   typedef enum logic [2:0] {
      PCG_RUN = 3'h1,
      PCG_SLEEP = 3'h2,
      PCG_DEEP = 3'h4
   } pcg_mode_t;
   localparam logic [1:0] PCG_MODE_SLEEP = 2'h1;
   localparam logic [1:0] PCG_MODE_DEEP = 2'h2;
   localparam int PCG_INT_BITS = 2;
endpackage : pcg_pkg

// File: pcg_gate_cell.sv
`timescale 1ns/1ns
// Glitch-free enable: latched while the clock is low, so the gated
// output can only change between pulses
module pcg_gate_cell (
   // Clock and enable
   input wire logic clk,
   input wire logic enable,
   // Gated clock and latched enable
   output logic gated_clk,
   output logic enable_seen
);
   logic hold;

   always_latch begin
      if (!clk) begin
         hold <= enable;
      end
   end

   assign gated_clk = clk & hold;
   assign enable_seen = hold;
endmodule : pcg_gate_cell

// File: pcg_fault_decode.sv
`timescale 1ns/1ns
// Maps a peripheral page to a one-hot hit on the unit that owns it
module pcg_fault_decode
   import pcg_pkg::*;
(
   // Peripheral page address bits
   input wire logic [7:0] page,
   // Unit hit vector: timer, sync serial, async serial, ports A..E
   output logic [PCG_UNIT_COUNT-1:0] hit
);
   always_comb begin
      hit = '0;
      hit[0] = (page == PCG_PAGE_GP_TIMER_ZERO);
      hit[1] = (page == PCG_PAGE_SYNC_SERIAL_ZERO);
      hit[2] = (page == PCG_PAGE_ASYNC_SERIAL_ZERO);
      hit[3] = (page == PCG_PAGE_PORT_A);
      hit[4] = (page == PCG_PAGE_PORT_B);
      hit[5] = (page == PCG_PAGE_PORT_C);
      hit[6] = (page == PCG_PAGE_PORT_D);
      hit[7] = (page == PCG_PAGE_PORT_E);
   end
endmodule : pcg_fault_decode

// File: pcg_clock_gating.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// Functional notes
// - Bit 16 of the first gating register clocks timer 0 when set, stops it when clear.
// - Bit 4 of the first gating register clocks the sync serial unit 0 when set.
// - Bit 0 of the first gating register clocks the async serial unit 0 when set.
// - A one bit delivers the unit clock, a zero bit stops it to save power.
// - Any access aimed at a unit whose gate is clear is answered with a bus fault.
// - Reset clears every gating bit so every unit starts unclocked.
// - Reserved bits 31:17, 15:5 and 3:1 of register one and 31:5 of register two read zero.
// - The run copy of register two sits at offset 0x108 and rules normal running.
// - Bits 4 to 0 of register two gate I/O ports E, D, C, B and A.
// - Run, sleep and deep-sleep copies of the gating registers exist side by side.
// - Sleep and deep-sleep copies apply only while the auto gating bit is set.
// - The sleep copy of register two sits at 0x118 and gates ports E to A in sleep.
// - The deep-sleep copy of register two sits at 0x128 and gates the same ports.
module pcg_clock_gating
   import pcg_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Register port
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Power mode request from the processor core
   input wire logic SLEEP_REQ,
   input wire logic DEEP_SLEEP_REQ,
   // Peripheral bus access watch
   input wire logic PERIPH_VALID,
   input wire logic [31:0] PERIPH_ADDR,
   output logic PERIPH_FAULT,
   // Gated unit clocks and enables
   output logic GP_TIMER_ZERO_CLK,
   output logic SYNC_SERIAL_ZERO_CLK,
   output logic ASYNC_SERIAL_ZERO_CLK,
   output logic [PCG_PORT_COUNT-1:0] IO_PORT_CLK,
   output logic [PCG_UNIT_COUNT-1:0] UNIT_ENABLE,
   // Interrupt
   output logic IRQ
);
   import pcg_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Register copies
   logic [31:0] gate_one_run;
   logic [31:0] gate_one_sleep;
   logic [31:0] gate_one_deep;
   logic [31:0] run_port_clock_gate_two;
   logic [31:0] sleep_port_clock_gate_two;
   logic [31:0] deep_sleep_port_clock_gate_two;
   logic [31:0] run_clock_configuration;
   logic auto_clock_gating;
   logic [31:0] fault_addr;
   logic [PCG_INT_BITS-1:0] int_stat;
   logic [PCG_INT_BITS-1:0] int_mask;
   pcg_mode_t mode;
   pcg_mode_t next_mode;
   logic [31:0] next_rdata;
   logic [PCG_UNIT_COUNT-1:0] next_enable;
   logic [PCG_UNIT_COUNT-1:0] unit_enable;
   logic [PCG_UNIT_COUNT-1:0] hit;
   logic [PCG_UNIT_COUNT-1:0] gated_clk;
   logic access_fault;
   logic [PCG_INT_BITS-1:0] event_set;

   assign auto_clock_gating = run_clock_configuration[PCG_BIT_AUTO_GATING];

   ////////////////////////////////////////////////////////////////////
   // Register writes; only implemented bits are stored
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         gate_one_run <= PCG_RESET_VALUE;
         gate_one_sleep <= PCG_RESET_VALUE;
         gate_one_deep <= PCG_RESET_VALUE;
         run_port_clock_gate_two <= PCG_RESET_VALUE;
         sleep_port_clock_gate_two <= PCG_RESET_VALUE;
         deep_sleep_port_clock_gate_two <= PCG_RESET_VALUE;
         run_clock_configuration <= PCG_RESET_VALUE;
      end else if (REG_WR) begin
         case (REG_ADDR)
            PCG_OFF_GATE_ONE: gate_one_run <= REG_WDATA & PCG_MASK_ONE;
            PCG_OFF_SLEEP_ONE: gate_one_sleep <= REG_WDATA & PCG_MASK_ONE;
            PCG_OFF_DEEP_ONE: gate_one_deep <= REG_WDATA & PCG_MASK_ONE;
            PCG_OFF_RUN_TWO: run_port_clock_gate_two <= REG_WDATA & PCG_MASK_TWO;
            PCG_OFF_SLEEP_TWO: sleep_port_clock_gate_two <= REG_WDATA & PCG_MASK_TWO;
            PCG_OFF_DEEP_TWO: deep_sleep_port_clock_gate_two <= REG_WDATA & PCG_MASK_TWO;
            PCG_OFF_CLK_CFG: run_clock_configuration <= REG_WDATA & PCG_MASK_CFG;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power mode tracking; deep sleep outranks sleep
   always_comb begin
      if (DEEP_SLEEP_REQ) begin
         next_mode = PCG_DEEP;
      end else if (SLEEP_REQ) begin
         next_mode = PCG_SLEEP;
      end else begin
         next_mode = PCG_RUN;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode <= PCG_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Selected gate set
   function automatic logic [PCG_UNIT_COUNT-1:0] pack_gates(
      input logic [31:0] one,
      input logic [31:0] two
   );
      pack_gates = {two[PCG_PORT_COUNT-1:0], one[PCG_BIT_ASYNC_SERIAL_ZERO],
                    one[PCG_BIT_SYNC_SERIAL_ZERO],
                    one[PCG_BIT_GP_TIMER_ZERO]};
   endfunction : pack_gates

   always_comb begin
      case (mode)
         PCG_RUN: next_enable = pack_gates(gate_one_run, run_port_clock_gate_two);
         PCG_SLEEP: begin
            if (auto_clock_gating) begin
               next_enable = pack_gates(gate_one_sleep, sleep_port_clock_gate_two);
            end else begin
               next_enable = pack_gates(gate_one_run, run_port_clock_gate_two);
            end
         end
         PCG_DEEP: begin
            if (auto_clock_gating) begin
               next_enable = pack_gates(gate_one_deep, deep_sleep_port_clock_gate_two);
            end else begin
               next_enable = pack_gates(gate_one_run, run_port_clock_gate_two);
            end
         end
         default: next_enable = pack_gates(gate_one_run, run_port_clock_gate_two);
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         unit_enable <= '0;
      end else begin
         unit_enable <= next_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Clock gates, one latch cell per unit to keep pulses whole
   genvar g;
   generate
      for (g = 0; g < PCG_UNIT_COUNT; g++) begin : gate_gen
         pcg_gate_cell u_cell (
            .clk(CLK),
            .enable(unit_enable[g]),
            .gated_clk(gated_clk[g]),
            .enable_seen()
         );
      end
   endgenerate

   // Gated clocks are clock nets, so they leave through the gate cells
   assign GP_TIMER_ZERO_CLK = gated_clk[0];
   assign SYNC_SERIAL_ZERO_CLK = gated_clk[1];
   assign ASYNC_SERIAL_ZERO_CLK = gated_clk[2];
   assign IO_PORT_CLK = gated_clk[PCG_UNIT_COUNT-1:3];
   assign UNIT_ENABLE = unit_enable;

   ////////////////////////////////////////////////////////////////////
   // Bus fault on access to an unclocked unit
   pcg_fault_decode u_decode (
      .page(PERIPH_ADDR[19:12]),
      .hit(hit)
   );

   assign access_fault = PERIPH_VALID && ((hit & ~unit_enable) != '0);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PERIPH_FAULT <= 1'b0;
         fault_addr <= PCG_RESET_VALUE;
      end else begin
         PERIPH_FAULT <= access_fault;
         if (access_fault) begin
            fault_addr <= PERIPH_ADDR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt: bit 0 fault, bit 1 mode change; set beats clear
   assign event_set = {next_mode != mode, access_fault};

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         int_stat <= '0;
      end else if (REG_WR && REG_ADDR == PCG_OFF_INT_STAT) begin
         int_stat <= (int_stat & ~REG_WDATA[PCG_INT_BITS-1:0]) | event_set;
      end else begin
         int_stat <= int_stat | event_set;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         int_mask <= '0;
      end else if (REG_WR && REG_ADDR == PCG_OFF_INT_MASK) begin
         int_mask <= REG_WDATA[PCG_INT_BITS-1:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= (next_irq_stat() & int_mask) != '0;
      end
   end

   // Status as it will stand after this edge, so IRQ tracks it
   function automatic logic [PCG_INT_BITS-1:0] next_irq_stat();
      if (REG_WR && REG_ADDR == PCG_OFF_INT_STAT) begin
         next_irq_stat = (int_stat & ~REG_WDATA[PCG_INT_BITS-1:0]) | event_set;
      end else begin
         next_irq_stat = int_stat | event_set;
      end
   endfunction : next_irq_stat

   ////////////////////////////////////////////////////////////////////
   // Read path; unmapped offsets read zero
   always_comb begin
      case (REG_ADDR)
         PCG_OFF_GATE_ONE: next_rdata = gate_one_run;
         PCG_OFF_SLEEP_ONE: next_rdata = gate_one_sleep;
         PCG_OFF_DEEP_ONE: next_rdata = gate_one_deep;
         PCG_OFF_RUN_TWO: next_rdata = run_port_clock_gate_two;
         PCG_OFF_SLEEP_TWO: next_rdata = sleep_port_clock_gate_two;
         PCG_OFF_DEEP_TWO: next_rdata = deep_sleep_port_clock_gate_two;
         PCG_OFF_CLK_CFG: next_rdata = run_clock_configuration;
         PCG_OFF_MODE: next_rdata = {29'h0, mode};
         PCG_OFF_FAULT_ADDR: next_rdata = fault_addr;
         PCG_OFF_INT_STAT: next_rdata = {30'h0, int_stat};
         PCG_OFF_INT_MASK: next_rdata = {30'h0, int_mask};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         REG_RDATA <= 32'h00000000;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end else begin
         REG_RDATA <= 32'h00000000;
      end
   end
endmodule : pcg_clock_gating

// File: pcg_clock_gating_properties.sv
`timescale 1ns/1ns
module pcg_clock_gating_checker
   import pcg_pkg::*;
(
   // Clock, reset and register port
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   // Mode and peripheral watch
   input wire logic SLEEP_REQ,
   input wire logic DEEP_SLEEP_REQ,
   input wire logic PERIPH_VALID,
   input wire logic [31:0] PERIPH_ADDR,
   input wire logic PERIPH_FAULT,
   // Gated outputs
   input wire logic GP_TIMER_ZERO_CLK,
   input wire logic [PCG_PORT_COUNT-1:0] IO_PORT_CLK,
   input wire logic [PCG_UNIT_COUNT-1:0] UNIT_ENABLE
);
   // Run mode only, so the sleep copies cannot mask a slip
   wire logic run = !SLEEP_REQ && !DEEP_SLEEP_REQ;
   wire logic tmr = PERIPH_VALID && PERIPH_ADDR[19:12] == PCG_PAGE_GP_TIMER_ZERO;
   sequence s_wr(off);
      (REG_WR && REG_ADDR == off && run) ##1 run;
   endsequence
   a_fault_cause: assert property (@(posedge CLK) disable iff (!RESETN)
      PERIPH_FAULT |-> $past(PERIPH_VALID)) else $error("fault without access");
   a_timer_fault: assert property (@(posedge CLK) disable iff (!RESETN)
      tmr && !UNIT_ENABLE[0] |=> PERIPH_FAULT) else $error("gated timer access not faulted");
   a_timer_pass: assert property (@(posedge CLK) disable iff (!RESETN)
      tmr && UNIT_ENABLE[0] |=> !PERIPH_FAULT) else $error("clocked timer access faulted");
   a_rdata_idle: assert property (@(posedge CLK) disable iff (!RESETN)
      !REG_RD |=> REG_RDATA == 32'h0) else $error("read data outside read slot");
   a_rsvd_one: assert property (@(posedge CLK) disable iff (!RESETN)
      REG_RD && REG_ADDR == PCG_OFF_GATE_ONE |=> (REG_RDATA & ~PCG_MASK_ONE) == 32'h0)
      else $error("reserved bits of gate one set");
   a_rsvd_two: assert property (@(posedge CLK) disable iff (!RESETN)
      REG_RD && REG_ADDR == PCG_OFF_RUN_TWO |=> (REG_RDATA & ~PCG_MASK_TWO) == 32'h0)
      else $error("reserved bits of gate two set");
   a_en_one: assert property (@(posedge CLK) disable iff (!RESETN) s_wr(PCG_OFF_GATE_ONE) |=>
      UNIT_ENABLE[2:0] == {$past(REG_WDATA[0], 2), $past(REG_WDATA[4], 2), $past(REG_WDATA[16], 2)})
      else $error("unit enables do not follow gate one");
   a_en_ports: assert property (@(posedge CLK) disable iff (!RESETN) s_wr(PCG_OFF_RUN_TWO) |=>
      UNIT_ENABLE[7:3] == $past(REG_WDATA[4:0], 2)) else $error("port enables do not follow gate two");
   // Sampled just before the fall, the gated clock shows the latched enable
   a_timer_clk: assert property (@(negedge CLK) disable iff (!RESETN)
      UNIT_ENABLE[0] == $past(UNIT_ENABLE[0]) |-> GP_TIMER_ZERO_CLK == UNIT_ENABLE[0])
      else $error("timer clock does not match enable");
   a_port_clk: assert property (@(negedge CLK) disable iff (!RESETN)
      UNIT_ENABLE[7:3] == $past(UNIT_ENABLE[7:3]) |-> IO_PORT_CLK == UNIT_ENABLE[7:3])
      else $error("port clocks do not match enables");
endmodule : pcg_clock_gating_checker

bind pcg_clock_gating pcg_clock_gating_checker pcg_clock_gating_checker_i (.CLK, .RESETN,
   .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SLEEP_REQ, .DEEP_SLEEP_REQ,
   .PERIPH_VALID, .PERIPH_ADDR, .PERIPH_FAULT, .GP_TIMER_ZERO_CLK, .IO_PORT_CLK, .UNIT_ENABLE);

// File: pcg_periph_master.sv
`timescale 1ns/1ns
module pcg_periph_master
   import pcg_pkg::*;
(
   input wire logic clk,
   output logic valid,
   output logic [31:0] addr
);
   initial begin
      valid = 1'b0;
      addr = 32'h0;
   end
   // Released address is inverted so a stale page never looks valid
   task automatic access(input logic [7:0] page);
      @(posedge clk);
      valid <= 1'b1;
      addr <= {12'h400, page, 12'h000};
      @(posedge clk);
      valid <= 1'b0;
      addr <= ~{12'h400, page, 12'h000};
   endtask : access
endmodule : pcg_periph_master

// File: test_pcg_clock_gating.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_pcg_clock_gating;
   import pcg_pkg::*;
   logic clk, rst_n, wr_s, rd_s, sleep, deep, pvalid, fault, irq, tclk, sclk, aclk;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, paddr;
   logic [4:0] pclk;
   logic [7:0] en, gclk;
   logic [7:0] pages [8];
   int n_errors = 0, check_count = 0, cycles = 0, m_one = 0, m_two = 0;
   pcg_clock_gating pcg_clock_gating_i (.CLK(clk), .RESETN(rst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SLEEP_REQ(sleep),
      .DEEP_SLEEP_REQ(deep), .PERIPH_VALID(pvalid), .PERIPH_ADDR(paddr), .PERIPH_FAULT(fault),
      .GP_TIMER_ZERO_CLK(tclk), .SYNC_SERIAL_ZERO_CLK(sclk), .ASYNC_SERIAL_ZERO_CLK(aclk),
      .IO_PORT_CLK(pclk), .UNIT_ENABLE(en), .IRQ(irq));
   pcg_periph_master pcg_periph_master_i (.clk(clk), .valid(pvalid), .addr(paddr));
   // Gated clocks in unit enable order
   assign gclk = {pclk, aclk, sclk, tclk};
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // Read data only stand in the slot after the strobe
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, exp)
   endtask : rd
   function automatic logic [7:0] exp_en();
      return {m_two[4:0], m_one[0], m_one[4], m_one[16]};
   endfunction : exp_en
   task automatic set_gates(input logic [31:0] o, input logic [31:0] t);
      wr(PCG_OFF_GATE_ONE, o);
      wr(PCG_OFF_RUN_TWO, t);
      m_one = o & PCG_MASK_ONE;
      m_two = t & PCG_MASK_TWO;
      repeat (2) @(posedge clk);
      #1;
      `CHK(en, exp_en())
      `CHK(gclk, exp_en())
      #50;
      `CHK(gclk, 8'h00)
   endtask : set_gates
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic final_report();
      $display("Mismatches %0d, comparisons %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   initial begin
      {rst_n, wr_s, rd_s, sleep, deep} = 5'h00;
      addr = 12'h000;
      wdata = 32'h0;
      pages = '{PCG_PAGE_GP_TIMER_ZERO, PCG_PAGE_SYNC_SERIAL_ZERO, PCG_PAGE_ASYNC_SERIAL_ZERO,
         PCG_PAGE_PORT_A, PCG_PAGE_PORT_B, PCG_PAGE_PORT_C, PCG_PAGE_PORT_D, PCG_PAGE_PORT_E};
      void'($urandom(32'hF59A566F));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(PCG_OFF_GATE_ONE, 32'h0);
      rd(PCG_OFF_RUN_TWO, 32'h0);
      `CHK(en, 8'h00)
      for (int i = 0; i < 8; i++) begin
         set_gates($urandom, $urandom);
         rd(PCG_OFF_GATE_ONE, m_one);
         rd(PCG_OFF_RUN_TWO, m_two);
      end
      set_gates(m_one | 32'h1, m_two ^ 32'h4);
      rd(12'h3FC, 32'h0);
      // Each unit faults while gated, then answers once its gate is set
      for (int u = 0; u < 8; u++) begin
         set_gates(32'h0, 32'h0);
         pcg_periph_master_i.access(pages[u]);
         #1;
         `CHK(fault, 1'b1)
         set_gates(u == 0 ? 32'h10000 : u == 1 ? 32'h10 : u == 2 ? 32'h1 : 32'h0,
            u > 2 ? 32'h1 << (u - 3) : 32'h0);
         pcg_periph_master_i.access(pages[u]);
         #1;
         `CHK(fault, 1'b0)
      end
      rd(PCG_OFF_FAULT_ADDR, {12'h400, PCG_PAGE_PORT_E, 12'h000});
      rd(PCG_OFF_INT_STAT, 32'h1);
      `CHK(irq, 1'b0)
      wr(PCG_OFF_INT_MASK, 32'h1);
      settle(2);
      `CHK(irq, 1'b1)
      wr(PCG_OFF_INT_STAT, 32'h3);
      settle(2);
      `CHK(irq, 1'b0)
      // Sleep copies stay idle until auto gating is switched on
      set_gates(32'h0, 32'h1C);
      wr(PCG_OFF_SLEEP_TWO, 32'hFFFFFFE3);
      wr(PCG_OFF_DEEP_TWO, 32'h5);
      wr(PCG_OFF_SLEEP_ONE, 32'hFFFFFFFF);
      rd(PCG_OFF_SLEEP_TWO, 32'h3);
      @(posedge clk);
      sleep <= 1'b1;
      settle(3);
      `CHK(en, exp_en())
      wr(PCG_OFF_CLK_CFG, PCG_MASK_CFG);
      settle(3);
      `CHK(en, 8'h1F)
      @(posedge clk);
      deep <= 1'b1;
      settle(3);
      `CHK(en, 8'h28)
      rd(PCG_OFF_MODE, 32'h4);
      @(posedge clk);
      sleep <= 1'b0;
      deep <= 1'b0;
      settle(3);
      `CHK(en, exp_en())
      rd(PCG_OFF_INT_STAT, 32'h2);
      `CHK(irq, 1'b0)
      final_report();
   end
endmodule : test_pcg_clock_gating
